// ---- bench/vtc_scan_model.sv ----
/*
 * Scan source: sweeps the pixel column, gives one-cycle mid-line
 * and line-end pulses.
 * Assumes run_i gates the pulses only.
 */
`timescale 1ns/10ps
module vtc_scan_model #(
    parameter int LINE_LEN = 40
) (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic run_i,
    output logic line_end_o,
    output logic half_line_o,
    output logic [10:0] pixel_col_o
);
    // Column runs while stopped so cursor hits stay exercised
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || pixel_col_o == 11'(LINE_LEN - 1)) begin
            pixel_col_o <= 11'h000;
        end else begin
            pixel_col_o <= pixel_col_o + 11'h001;
        end
    end

    // Pulses land on the last column and mid-line
    always_ff @(posedge sys_clk_i) begin
        line_end_o <= !reset_i && run_i && pixel_col_o == 11'(LINE_LEN - 2);
        half_line_o <= !reset_i && run_i && pixel_col_o == 11'(LINE_LEN / 2 - 2);
    end
endmodule

// ---- bench/vtc_top_sva.sv ----
/*
 * Checker for vtc_top: reserved readback bits and output timing
 * against line steps.
 * Assumes it is bound to vtc_top and sees only its ports.
 */
`timescale 1ns/10ps
module vtc_top_sva (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic line_end_i,
    input wire logic half_line_i,
    input wire logic interlace_i,
    input wire logic split_compare_enable_i,
    input wire logic vblank_o,
    input wire logic crt_vsync_o,
    input wire logic panel_vsync_o,
    input wire logic frame_start_o,
    input wire logic fetch_reset_o,
    input wire logic offset_load_o,
    input wire logic cursor_hit_o
);
    // ----------------------------------------
    // Helpers and assertions
    // ----------------------------------------
    // Counter step; half-lines count only when interlaced
    wire adv = line_end_i | (interlace_i & half_line_i);

    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    AST_SCAN_RSVD: assert property (reg_rd_i && reg_addr_i == vtc_pkg::VTC_OFS_CURRENT_SCANLINE
        |=> reg_rdata_o[31:11] == 21'h000000) else $error("scanline upper bits not zero");
    AST_CURY_RSVD: assert property (reg_rd_i && reg_addr_i == vtc_pkg::VTC_OFS_CURSOR_VERTICAL
        |=> reg_rdata_o[31:16] == 16'h0000 && !reg_rdata_o[10]) else $error("cursor Y reserved bits set");
    AST_SPLIT_RSVD: assert property (reg_rd_i && reg_addr_i == vtc_pkg::VTC_OFS_SPLIT_COMPARE
        |=> reg_rdata_o[31:11] == 21'h000000) else $error("split compare upper bits set");
    // Levels may only move at a counter step
    AST_VBLANK_STEP: assert property ($changed(vblank_o) |-> $past(adv))
        else $error("blank changed without a line step");
    AST_CRT_STEP: assert property ($changed(crt_vsync_o) |-> $past(adv))
        else $error("CRT sync changed without a line step");
    AST_PANEL_STEP: assert property ($changed(panel_vsync_o) |-> $past(adv))
        else $error("panel sync changed without a line step");
    AST_FRAME_STEP: assert property (frame_start_o |-> $past(adv) && !$past(frame_start_o))
        else $error("frame start without a wrap step");
    AST_FETCH_GATED: assert property (fetch_reset_o |-> $past(split_compare_enable_i) && $past(adv))
        else $error("fetch reset while split disabled");
    AST_ALT_NO_CURSOR: assert property (offset_load_o |-> !cursor_hit_o && $past(adv))
        else $error("cursor shown during alternate compare");
endmodule

bind vtc_top vtc_top_sva u_sva (.sys_clk_i, .reset_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .line_end_i,
    .half_line_i, .interlace_i, .split_compare_enable_i, .vblank_o, .crt_vsync_o, .panel_vsync_o,
    .frame_start_o, .fetch_reset_o, .offset_load_o, .cursor_hit_o);

// ---- bench/vtc_top_tb.sv ----
/*
 * Self-checking bench for vtc_top: registers, lock, timing outputs,
 * cursor hits, split and alternate compares.
 * Assumes the scan model drives the timing inputs.
 */
`timescale 1ns/10ps
module vtc_top_tb;
    localparam logic [31:0] MSK [8] = '{32'h07FF07FF, 32'h07FF07FF, 32'h07FF07FF, 32'h0000FFFF,
        32'h00000000, 32'h0000FBFF, 32'h000007FF, 32'h00000001};
    logic sys_clk_i = 1'b0, reset_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, run = 1'b0, rd_d = 1'b0;
    logic interlace_i = 1'b0, lock_released_i = 1'b1, split_compare_enable_i = 1'b0, hit, adv;
    logic [15:0] reg_addr_i = 16'h0000, o;
    logic [31:0] reg_wdata_i = 32'h00000000, reg_rdata_o, lcx, lcy;
    logic [10:0] vtotal_i = 11'h014, pixel_col_i, cnt, eh;
    logic line_end_i, half_line_i, vblank_o, crt_vsync_o, panel_vsync_o, frame_start_o;
    logic fetch_reset_o, offset_load_o, cursor_hit_o;
    logic [4:0] cursor_row_o, cursor_col_o;
    logic [5:0] ev;
    logic [11:0] rw, cl;
    logic [31:0] sh [8];
    logic [31:0] q [$];
    int n_fail = 0, tests_run = 0;

    vtc_top uut (.sys_clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .line_end_i, .half_line_i, .interlace_i, .vtotal_i, .pixel_col_i, .lock_released_i,
        .split_compare_enable_i, .vblank_o, .crt_vsync_o, .panel_vsync_o, .frame_start_o,
        .fetch_reset_o, .offset_load_o, .cursor_hit_o, .cursor_row_o, .cursor_col_o);
    vtc_scan_model u_scan (.sys_clk_i, .reset_i, .run_i(run), .line_end_o(line_end_i),
        .half_line_o(half_line_i), .pixel_col_o(pixel_col_i));

    // ----------------------------------------
    // Clock, compares and reference model
    // ----------------------------------------
    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_out(input logic [10:0] got, input logic [10:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // End wins over start on one line
    function automatic logic lvl(input logic cur, input logic [10:0] c, input logic [31:0] r);
        if (c == r[26:16]) return 1'b0;
        if (c == r[10:0]) return 1'b1;
        return cur;
    endfunction

    // Expected readback; unmapped words read zero
    function automatic logic [31:0] expv(input logic [15:0] a);
        logic [15:0] d;
        d = a - 16'h8344;
        if (d > 16'h1C || d[1:0] != 2'b00) return 32'h00000000;
        if (d[4:2] == 3'h4) return {21'h000000, cnt};
        return sh[d[4:2]];
    endfunction

    // One bus cycle per call; op 0 idle, 1 write, 2 read
    task automatic bus(input int op, input logic [15:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        reg_wr_i <= (op == 1);
        reg_rd_i <= (op == 2);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        if (op == 2) begin
            fork
                begin
                    @(posedge sys_clk_i);
                    #1 q.push_back(expv(a));
                end
            join_none
        end
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge sys_clk_i) begin
        if (rd_d) chk_rd(reg_rdata_o, q.pop_front());
        rd_d = reg_rd_i && !reset_i;
    end

    // Shadow of the block; outputs lag it by one edge
    always @(posedge sys_clk_i) begin
        if (reset_i) begin
            cnt = 11'h000;
            ev = 6'h00;
            eh = 11'h000;
            lcx = 32'h00000000;
            lcy = 32'h00000000;
            sh = '{default: 32'h00000000};
        end else begin
            chk_out({5'h00, vblank_o, crt_vsync_o, panel_vsync_o, frame_start_o, fetch_reset_o, offset_load_o},
                {5'h00, ev});
            chk_out({cursor_hit_o, cursor_hit_o ? {cursor_row_o, cursor_col_o} : 10'h000}, eh);
            rw = {1'b0, cnt} - {2'b00, lcy[9:0]} + {7'h00, lcy[15:11]};
            cl = {1'b0, pixel_col_i} - {1'b0, lcx[10:0]} + {7'h00, lcx[15:11]};
            hit = !sh[7][0] && cnt >= {1'b0, lcy[9:0]} && pixel_col_i >= lcx[10:0] && rw < 12'h020 && cl < 12'h020;
            eh = hit ? {1'b1, rw[4:0], cl[4:0]} : 11'h000;
            adv = line_end_i | (interlace_i & half_line_i);
            ev[2:0] = 3'h0;
            if (adv) begin
                ev[5] = lvl(ev[5], cnt, sh[0]);
                ev[4] = lvl(ev[4], cnt, sh[1]);
                ev[3] = lvl(ev[3], cnt, sh[2]);
                ev[2:0] = {cnt == vtotal_i, split_compare_enable_i && cnt == sh[6][10:0],
                    sh[7][0] && cnt == {1'b0, sh[5][9:0]}};
                if (cnt == vtotal_i) begin
                    lcx = sh[3];
                    lcy = sh[5];
                end
                cnt = (cnt == vtotal_i) ? 11'h000 : cnt + 11'h001;
            end
            o = reg_addr_i - 16'h8344;
            if (reg_wr_i && o <= 16'h1C && o[1:0] == 2'b00 && o[4:2] != 3'h4
                && (o[4:2] > 3'h2 || lock_released_i)) sh[o[4:2]] = reg_wdata_i & MSK[o[4:2]];
        end
    end

    task automatic give_verdict();
        $display("checks=%0d mismatches=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Hang guard, far past the ~4400-cycle run
    initial begin
        #500000;
        n_fail++;
        give_verdict();
    end

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(39625));
        repeat (20) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        // All words and one unmapped, random data, read back
        for (int i = 0; i < 9; i++) begin
            bus(1, 16'h8344 + 16'(4 * i), $urandom);
            bus(2, 16'h8344 + 16'(4 * i), '0);
        end
        // Locked timing words keep contents
        lock_released_i <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            bus(1, 16'h8344 + 16'(4 * i), $urandom);
            bus(2, 16'h8344 + 16'(4 * i), '0);
        end
        lock_released_i <= 1'b1;
        bus(1, 16'h8344, 32'h0013000F);
        bus(1, 16'h8348, 32'h00110010);
        bus(1, 16'h834C, 32'h00120010);
        bus(1, 16'h8350, 32'h00001003);
        bus(1, 16'h8358, 32'h0000F005);
        bus(1, 16'h835C, 32'h00000007);
        bus(1, 16'h8360, 32'h00000000);
        run <= 1'b1;
        // Cursor moved mid-frame; split enable toggles at random
        repeat (4) begin
            repeat (300) begin
                bus(0, '0, '0);
                split_compare_enable_i <= 1'($urandom);
            end
            bus(1, 16'h8350, {16'h0000, 5'($urandom), 11'($urandom_range(40))});
        end
        // Cursor Y as offset-load compare, cursor off
        bus(1, 16'h8360, 32'h00000001);
        bus(1, 16'h8358, 32'h00000009);
        repeat (900) bus(0, '0, '0);
        bus(1, 16'h8360, 32'h00000000);
        // Interlaced with an odd half-line total
        bus(1, 16'h8344, 32'h00290025);
        interlace_i <= 1'b1;
        vtotal_i <= 11'h029;
        repeat (2000) bus(0, '0, '0);
        // Second reset in mid-run
        reset_i <= 1'b1;
        repeat (3) bus(0, '0, '0);
        reset_i <= 1'b0;
        repeat (200) bus(0, '0, '0);
        // Scanline read twice, counter still
        run <= 1'b0;
        repeat (4) bus(0, '0, '0);
        bus(2, vtc_pkg::VTC_OFS_CURRENT_SCANLINE, '0);
        bus(2, vtc_pkg::VTC_OFS_CURRENT_SCANLINE, '0);
        repeat (4) bus(0, '0, '0);
        give_verdict();
    end
endmodule

// ---- hw/vtc_cursor_latch.sv ----
/*
 * Frame-start capture of the cursor coordinates and hot-spot offsets.
 * Assumes frame_start_i is a one-cycle pulse at the top of each frame.
 */
`timescale 1ns/10ps
module vtc_cursor_latch (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic frame_start_i,
    input wire logic [10:0] x_i,
    input wire logic [4:0] x_hot_i,
    input wire logic [9:0] y_i,
    input wire logic [4:0] y_hot_i,
    output logic [10:0] x_o,
    output logic [4:0] x_hot_o,
    output logic [9:0] y_o,
    output logic [4:0] y_hot_o
);

    // Only frame start loads, so a mid-frame move never tears the shape
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            x_o <= vtc_pkg::VTC_LINE_RST;
            x_hot_o <= vtc_pkg::VTC_HOT_RST;
            y_o <= vtc_pkg::VTC_CURY_RST;
            y_hot_o <= vtc_pkg::VTC_HOT_RST;
        end else if (frame_start_i) begin
            x_o <= x_i;
            x_hot_o <= x_hot_i;
            y_o <= y_i;
            y_hot_o <= y_hot_i;
        end
    end

endmodule

// ---- hw/vtc_line_counter.sv ----
/*
 * Vertical line counter, stepped by line-end and, when interlaced,
 * mid-line pulses.
 * Assumes both pulses are one cycle wide on sys_clk_i.
 */
`timescale 1ns/10ps
module vtc_line_counter (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic line_end_i,
    input wire logic half_line_i,
    input wire logic interlace_i,
    input wire logic [10:0] vtotal_i,
    output logic [10:0] count_o,
    output logic advance_o,
    output logic wrap_o
);

    logic [10:0] count_q;

    // Interlaced frames step twice per line, so odd totals split a line
    assign advance_o = line_end_i | (interlace_i & half_line_i);
    assign wrap_o = advance_o && (count_q == vtotal_i);
    assign count_o = count_q;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            count_q <= vtc_pkg::VTC_LINE_RST;
        end else if (wrap_o) begin
            count_q <= vtc_pkg::VTC_LINE_RST;
        end else if (advance_o) begin
            count_q <= 11'(count_q + 11'h001);
        end
    end

endmodule

// ---- hw/vtc_pkg.sv ----
/*
 * Constants of the vertical timing block: register addresses,
 * field layout and reset values.
 * Assumes byte addresses of 32-bit words.
 */
package vtc_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam int VTC_ADDR_W = 16;
    localparam logic [15:0] VTC_OFS_VBLANK_LINES = 16'h8344;
    localparam logic [15:0] VTC_OFS_CRT_VSYNC_LINES = 16'h8348;
    localparam logic [15:0] VTC_OFS_PANEL_VSYNC_LINES = 16'h834C;
    localparam logic [15:0] VTC_OFS_CURSOR_HORIZONTAL = 16'h8350;
    localparam logic [15:0] VTC_OFS_CURRENT_SCANLINE = 16'h8354;
    localparam logic [15:0] VTC_OFS_CURSOR_VERTICAL = 16'h8358;
    localparam logic [15:0] VTC_OFS_SPLIT_COMPARE = 16'h835C;
    localparam logic [15:0] VTC_OFS_CURSOR_MODE = 16'h8360;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int VTC_LINE_W = 11;
    localparam int VTC_LO_LSB = 0;
    localparam int VTC_HI_LSB = 16;
    localparam int VTC_HOT_LSB = 11;
    localparam int VTC_HOT_W = 5;
    localparam int VTC_CURY_W = 10;
    localparam int VTC_ALT_BIT = 0;
    localparam int VTC_DIFF_W = 12;

    // Cursor pattern is 32x32
    localparam logic [11:0] VTC_PATTERN_SIZE = 12'h020;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [10:0] VTC_LINE_RST = 11'h000;
    localparam logic [4:0] VTC_HOT_RST = 5'h00;
    localparam logic [9:0] VTC_CURY_RST = 10'h000;
    localparam logic [31:0] VTC_RDATA_IDLE = 32'h0000_0000;

endpackage

// ---- hw/vtc_top.sv ----
/*
 * Vertical timing and cursor position logic of a display controller:
 * blank and sync compares, scanline readback, cursor hits,
 * alternate and split-screen line compares.
 * Assumes horizontal timing gives line-end, mid-line and column
 * inputs on sys_clk_i; lock and split enable come from
 * registers elsewhere.
 */
// Functional notes
// - Blank end field bits 26:16 holds line minus one where blank deasserts.
// - Blank start field bits 10:0 holds line minus one where blank asserts.
// - CRT sync end field bits 26:16 holds line minus one where sync deasserts.
// - CRT sync start field bits 10:0 holds line minus one where sync asserts.
// - Interlaced counter steps twice per line; odd totals give mid-line sync.
// - Panel sync goes inactive after its end field line and active again after its start field line.
// - Cursor coordinates are captured only at frame start.
// - Five-bit horizontal hot spot picks first shown pattern column.
// - Eleven-bit cursor X gives upper-left pixel from origin.
// - Read-only eleven-bit current scanline; upper bits read zero.
// - Five-bit vertical hot spot picks first shown pattern line.
// - Ten-bit cursor Y gives upper-left line; bit 10 reserved.
// - Cursor Y may act as offset-load line compare; cursor then disabled.
// - Eleven-bit split compare line in low bits; upper bits reserved.
// - Split line hit with enable set resets the fetch address.
`timescale 1ns/10ps
module vtc_top (
    input wire logic sys_clk_i,
    input wire logic reset_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic line_end_i,
    input wire logic half_line_i,
    input wire logic interlace_i,
    input wire logic [10:0] vtotal_i,
    input wire logic [10:0] pixel_col_i,
    input wire logic lock_released_i,
    input wire logic split_compare_enable_i,
    output logic vblank_o,
    output logic crt_vsync_o,
    output logic panel_vsync_o,
    output logic frame_start_o,
    output logic fetch_reset_o,
    output logic offset_load_o,
    output logic cursor_hit_o,
    output logic [4:0] cursor_row_o,
    output logic [4:0] cursor_col_o
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Compare fields hold target line minus one: the output flips when the
    // counter leaves that value, i.e. as it enters the named line
    function automatic logic line_hit(input logic advance, input logic [10:0] count,
                                      input logic [10:0] field);
        line_hit = advance && (count == field);
    endfunction

    // Pack a lower and upper line field into a read word, reserved bits zero
    function automatic logic [31:0] pack_pair(input logic [10:0] lo, input logic [10:0] hi);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[vtc_pkg::VTC_LO_LSB +: vtc_pkg::VTC_LINE_W] = lo;
        w[vtc_pkg::VTC_HI_LSB +: vtc_pkg::VTC_LINE_W] = hi;
        pack_pair = w;
    endfunction

    // Distance into the cursor pattern, offset by hot spot; in range flag on top
    function automatic logic [5:0] pattern_index(input logic [10:0] pos, input logic [10:0] origin,
                                                 input logic [4:0] hot);
        logic [11:0] diff;
        logic [11:0] idx;
        diff = 12'({1'b0, pos} - {1'b0, origin});
        idx = 12'(diff + {7'h00, hot});
        pattern_index = {(!diff[11] && idx < vtc_pkg::VTC_PATTERN_SIZE), idx[4:0]};
    endfunction

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [10:0] vblank_start_q;
    logic [10:0] vblank_end_q;
    logic [10:0] vsync_start_q;
    logic [10:0] vsync_end_q;
    logic [10:0] panel_start_q;
    logic [10:0] panel_end_q;
    logic [10:0] cursor_x_q;
    logic [4:0] cursor_x_hot_q;
    logic [9:0] cursor_y_q;
    logic [4:0] cursor_y_hot_q;
    logic [10:0] split_line_q;
    logic alt_compare_q;

    logic [10:0] scanline_now;
    logic advance;
    logic wrap;
    logic [10:0] lat_x;
    logic [4:0] lat_x_hot;
    logic [9:0] lat_y;
    logic [4:0] lat_y_hot;
    logic [5:0] row_idx;
    logic [5:0] col_idx;
    logic wr_locked_ok;

    // Timing registers are shut while the lock is held
    assign wr_locked_ok = reg_wr_i && lock_released_i;

    // Locked vertical timing registers; only field bits are stored
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            vblank_start_q <= vtc_pkg::VTC_LINE_RST;
            vblank_end_q <= vtc_pkg::VTC_LINE_RST;
            vsync_start_q <= vtc_pkg::VTC_LINE_RST;
            vsync_end_q <= vtc_pkg::VTC_LINE_RST;
            panel_start_q <= vtc_pkg::VTC_LINE_RST;
            panel_end_q <= vtc_pkg::VTC_LINE_RST;
        end else if (wr_locked_ok) begin
            unique case (reg_addr_i)
                vtc_pkg::VTC_OFS_VBLANK_LINES: begin
                    vblank_start_q <= reg_wdata_i[vtc_pkg::VTC_LO_LSB +: vtc_pkg::VTC_LINE_W];
                    vblank_end_q <= reg_wdata_i[vtc_pkg::VTC_HI_LSB +: vtc_pkg::VTC_LINE_W];
                end
                vtc_pkg::VTC_OFS_CRT_VSYNC_LINES: begin
                    vsync_start_q <= reg_wdata_i[vtc_pkg::VTC_LO_LSB +: vtc_pkg::VTC_LINE_W];
                    vsync_end_q <= reg_wdata_i[vtc_pkg::VTC_HI_LSB +: vtc_pkg::VTC_LINE_W];
                end
                vtc_pkg::VTC_OFS_PANEL_VSYNC_LINES: begin
                    panel_start_q <= reg_wdata_i[vtc_pkg::VTC_LO_LSB +: vtc_pkg::VTC_LINE_W];
                    panel_end_q <= reg_wdata_i[vtc_pkg::VTC_HI_LSB +: vtc_pkg::VTC_LINE_W];
                end
                default: begin
                end
            endcase
        end
    end

    // Unlocked cursor, split and mode registers
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cursor_x_q <= vtc_pkg::VTC_LINE_RST;
            cursor_x_hot_q <= vtc_pkg::VTC_HOT_RST;
            cursor_y_q <= vtc_pkg::VTC_CURY_RST;
            cursor_y_hot_q <= vtc_pkg::VTC_HOT_RST;
            split_line_q <= vtc_pkg::VTC_LINE_RST;
            alt_compare_q <= 1'b0;
        end else if (reg_wr_i) begin
            unique case (reg_addr_i)
                vtc_pkg::VTC_OFS_CURSOR_HORIZONTAL: begin
                    cursor_x_q <= reg_wdata_i[vtc_pkg::VTC_LO_LSB +: vtc_pkg::VTC_LINE_W];
                    cursor_x_hot_q <= reg_wdata_i[vtc_pkg::VTC_HOT_LSB +: vtc_pkg::VTC_HOT_W];
                end
                vtc_pkg::VTC_OFS_CURSOR_VERTICAL: begin
                    cursor_y_q <= reg_wdata_i[vtc_pkg::VTC_LO_LSB +: vtc_pkg::VTC_CURY_W];
                    cursor_y_hot_q <= reg_wdata_i[vtc_pkg::VTC_HOT_LSB +: vtc_pkg::VTC_HOT_W];
                end
                vtc_pkg::VTC_OFS_SPLIT_COMPARE: begin
                    split_line_q <= reg_wdata_i[vtc_pkg::VTC_LO_LSB +: vtc_pkg::VTC_LINE_W];
                end
                vtc_pkg::VTC_OFS_CURSOR_MODE: begin
                    alt_compare_q <= reg_wdata_i[vtc_pkg::VTC_ALT_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------

    // Data stand one cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk_i) begin
        if (reset_i || !reg_rd_i) begin
            reg_rdata_o <= vtc_pkg::VTC_RDATA_IDLE;
        end else begin
            unique case (reg_addr_i)
                vtc_pkg::VTC_OFS_VBLANK_LINES: reg_rdata_o <= pack_pair(vblank_start_q, vblank_end_q);
                vtc_pkg::VTC_OFS_CRT_VSYNC_LINES: reg_rdata_o <= pack_pair(vsync_start_q, vsync_end_q);
                vtc_pkg::VTC_OFS_PANEL_VSYNC_LINES: reg_rdata_o <= pack_pair(panel_start_q, panel_end_q);
                vtc_pkg::VTC_OFS_CURSOR_HORIZONTAL: begin
                    reg_rdata_o <= {16'h0000, cursor_x_hot_q, cursor_x_q};
                end
                vtc_pkg::VTC_OFS_CURRENT_SCANLINE: begin
                    reg_rdata_o <= pack_pair(scanline_now, vtc_pkg::VTC_LINE_RST);
                end
                vtc_pkg::VTC_OFS_CURSOR_VERTICAL: begin
                    reg_rdata_o <= {16'h0000, cursor_y_hot_q, 1'b0, cursor_y_q};
                end
                vtc_pkg::VTC_OFS_SPLIT_COMPARE: reg_rdata_o <= pack_pair(split_line_q, vtc_pkg::VTC_LINE_RST);
                vtc_pkg::VTC_OFS_CURSOR_MODE: reg_rdata_o <= {31'h0000_0000, alt_compare_q};
                default: reg_rdata_o <= vtc_pkg::VTC_RDATA_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Line counter and cursor capture
    // ------------------------------------------------------------

    // Counter shares sys_clk_i, so a single read is already coherent;
    // the double read that software performs stays harmless
    vtc_line_counter u_counter (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .line_end_i(line_end_i),
        .half_line_i(half_line_i),
        .interlace_i(interlace_i),
        .vtotal_i(vtotal_i),
        .count_o(scanline_now),
        .advance_o(advance),
        .wrap_o(wrap)
    );

    vtc_cursor_latch u_cursor (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .frame_start_i(wrap),
        .x_i(cursor_x_q),
        .x_hot_i(cursor_x_hot_q),
        .y_i(cursor_y_q),
        .y_hot_i(cursor_y_hot_q),
        .x_o(lat_x),
        .x_hot_o(lat_x_hot),
        .y_o(lat_y),
        .y_hot_o(lat_y_hot)
    );

    // ------------------------------------------------------------
    // Vertical blank and sync
    // ------------------------------------------------------------

    // End wins when start and end share a line
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            vblank_o <= 1'b0;
        end else if (line_hit(advance, scanline_now, vblank_end_q)) begin
            vblank_o <= 1'b0;
        end else if (line_hit(advance, scanline_now, vblank_start_q)) begin
            vblank_o <= 1'b1;
        end
    end

    // Half-line steps let interlaced sync start mid-line on alternate fields
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            crt_vsync_o <= 1'b0;
        end else if (line_hit(advance, scanline_now, vsync_end_q)) begin
            crt_vsync_o <= 1'b0;
        end else if (line_hit(advance, scanline_now, vsync_start_q)) begin
            crt_vsync_o <= 1'b1;
        end
    end

    // Panel sync holds its level between the two compares
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            panel_vsync_o <= 1'b0;
        end else if (line_hit(advance, scanline_now, panel_end_q)) begin
            panel_vsync_o <= 1'b0;
        end else if (line_hit(advance, scanline_now, panel_start_q)) begin
            panel_vsync_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Frame events
    // ------------------------------------------------------------

    // Pulses fire as the counter leaves the compared line
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            frame_start_o <= 1'b0;
            fetch_reset_o <= 1'b0;
            offset_load_o <= 1'b0;
        end else begin
            frame_start_o <= wrap;
            fetch_reset_o <= split_compare_enable_i && line_hit(advance, scanline_now, split_line_q);
            offset_load_o <= alt_compare_q && line_hit(advance, scanline_now, {1'b0, cursor_y_q});
        end
    end

    // ------------------------------------------------------------
    // Cursor hit
    // ------------------------------------------------------------
    assign row_idx = pattern_index(scanline_now, {1'b0, lat_y}, lat_y_hot);
    assign col_idx = pattern_index(pixel_col_i, lat_x, lat_x_hot);

    // Hot spot shifts the pattern so only its far part shows at the edge;
    // the alternate compare use takes the Y field away from the cursor
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            cursor_hit_o <= 1'b0;
            cursor_row_o <= vtc_pkg::VTC_HOT_RST;
            cursor_col_o <= vtc_pkg::VTC_HOT_RST;
        end else begin
            cursor_hit_o <= row_idx[5] && col_idx[5] && !alt_compare_q;
            cursor_row_o <= row_idx[4:0];
            cursor_col_o <= col_idx[4:0];
        end
    end

endmodule
